// File: core/btzm_consts.vh
// Constants of the battery temperature zone monitor.
// Assumes Verilog-2005 and SystemVerilog includers; definitions only.
`ifndef BTZM_CONSTS_VH
`define BTZM_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define BTZM_OFS_CFG_A        8'h00
`define BTZM_OFS_CFG_F        8'h04
`define BTZM_OFS_CFG_H        8'h08
`define BTZM_OFS_NORMAL       8'h0c
`define BTZM_OFS_CFG_I        8'h10
`define BTZM_OFS_STATUS_A     8'h14
`define BTZM_OFS_INT_FLAGS    8'h18
`define BTZM_OFS_INT_MASK     8'h1c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BTZM_HOT_LSB          0
`define BTZM_WARM_LSB         2
`define BTZM_COOL_LSB         4
`define BTZM_COLD_LSB         6
`define BTZM_EN_BIT           0
`define BTZM_MOD_LSB          2
`define BTZM_NCUR_LSB         8
`define BTZM_ST_BIAS_BIT      3
`define BTZM_ST_FAULT_BIT     4
`define BTZM_ST_MOD_BIT       5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define BTZM_RST_CFG_A        8'h00
`define BTZM_RST_EN           1'b0
`define BTZM_RST_CODE6        6'h00
`define BTZM_RST_MUX          4'h0
`define BTZM_RST_MASK         1'b1

// ----------------------------------------------------------------------
// Zone codes, channel codes, charger state codes, trip level bases
// ----------------------------------------------------------------------
`define BTZM_ZONE_OFF         3'h0
`define BTZM_ZONE_COLD        3'h1
`define BTZM_ZONE_COOL        3'h2
`define BTZM_ZONE_NORMAL      3'h3
`define BTZM_ZONE_WARM        3'h4
`define BTZM_ZONE_HOT         3'h5
`define BTZM_MUX_OFF          4'h0
`define BTZM_MUX_SENSE        4'h7
`define BTZM_MUX_BIAS         4'h8
`define BTZM_CHG_TEMP_FAULT   4'hf
`define BTZM_COLD_BASE        0
`define BTZM_COOL_BASE        2
`define BTZM_WARM_BASE        6
`define BTZM_HOT_BASE         8
`define BTZM_RESP_OKAY        2'h0
`define BTZM_RESP_SLVERR      2'h2

`endif

// File: core/btzm_sync.v
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none

module btzm_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] din,
    output reg  [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] stage1;

    always @(posedge clk) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{1'b0}};
            dout   <= {WIDTH{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

`default_nettype wire

// File: core/btzm_trip_pick.v
// Picks one comparator result out of a group of four trip levels.
// Assumes level index rises as the trip voltage falls.
`timescale 1ns/10ps
`default_nettype none

module btzm_trip_pick #(
    parameter BASE   = 0,
    parameter LEVELS = 12
) (
    input  wire [LEVELS-1:0] above,
    input  wire [1:0]        sel,
    output wire              hit
);

    wire [3:0] quad;

    assign quad = above[BASE+3:BASE];
    assign hit  = quad[sel];

endmodule

`default_nettype wire

// File: core/btzm_monitor.v
// Battery temperature zone monitor with AXI4-Lite register access.
// Assumes comparators and supply-valid arrive asynchronously; the
// charger state machine shares clk.
`timescale 1ns/10ps
`default_nettype none
`include "btzm_consts.vh"

module btzm_monitor #(
    parameter ADDR_W = 8,
    parameter LEVELS = 12
) (
    input  wire              clk,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    input  wire [LEVELS-1:0] trip_above,
    input  wire              charge_input_supply,
    input  wire [3:0]        chg_state_in,
    output reg  [3:0]        chg_state_out,
    output reg               charge_stop,
    output reg               modified_state,
    output reg  [5:0]        charge_voltage_sel,
    output reg  [5:0]        charge_current_sel,
    output reg               timer_pause,
    output reg               fast_timer_restart,
    output reg               topoff_timer_restart,
    output reg               thermistor_bias_pin,
    output reg  [3:0]        monitor_channel_select,
    output reg               analog_monitor_enable,
    output reg               irq
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    reg [7:0]        trip_cfg;
    reg              temp_monitor_enable;
    reg [5:0]        modified_charge_current;
    reg [5:0]        modified_charge_voltage;
    reg [5:0]        normal_charge_voltage;
    reg [5:0]        normal_charge_current;
    reg [2:0]        temp_zone_status;
    reg              temp_zone_change_flag;
    reg              temp_zone_change_mask;

    reg              aw_got;
    reg              w_got;
    reg [ADDR_W-1:0] aw_addr;
    reg [31:0]       w_data;
    reg [3:0]        w_strb;

    reg              in_fault;
    reg [3:0]        saved_state;

    wire [1:0] hot_trip_select;
    wire [1:0] warm_trip_select;
    wire [1:0] cool_trip_select;
    wire [1:0] cold_trip_select;

    assign hot_trip_select  = trip_cfg[`BTZM_HOT_LSB+1:`BTZM_HOT_LSB];
    assign warm_trip_select = trip_cfg[`BTZM_WARM_LSB+1:`BTZM_WARM_LSB];
    assign cool_trip_select = trip_cfg[`BTZM_COOL_LSB+1:`BTZM_COOL_LSB];
    assign cold_trip_select = trip_cfg[`BTZM_COLD_LSB+1:`BTZM_COLD_LSB];

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    wire [LEVELS-1:0] above_s;
    wire              supply_s;

    btzm_sync #(
        .WIDTH (LEVELS)
    ) u_sync_trip (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (trip_above),
        .dout  (above_s)
    );

    btzm_sync #(
        .WIDTH (1)
    ) u_sync_supply (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (charge_input_supply),
        .dout  (supply_s)
    );

    // ------------------------------------------------------------------
    // Trip level selection
    // ------------------------------------------------------------------
    wire cold_hit;
    wire cool_hit;
    wire warm_hit;
    wire hot_hit;

    // Twelve levels, each threshold picks from a group of four; cold and cool share levels 2-3, warm and hot 8-9
    btzm_trip_pick #(
        .BASE   (`BTZM_COLD_BASE),
        .LEVELS (LEVELS)
    ) u_pick_cold (
        .above (above_s),
        .sel   (cold_trip_select),
        .hit   (cold_hit)
    );

    btzm_trip_pick #(
        .BASE   (`BTZM_COOL_BASE),
        .LEVELS (LEVELS)
    ) u_pick_cool (
        .above (above_s),
        .sel   (cool_trip_select),
        .hit   (cool_hit)
    );

    btzm_trip_pick #(
        .BASE   (`BTZM_WARM_BASE),
        .LEVELS (LEVELS)
    ) u_pick_warm (
        .above (above_s),
        .sel   (warm_trip_select),
        .hit   (warm_hit)
    );

    btzm_trip_pick #(
        .BASE   (`BTZM_HOT_BASE),
        .LEVELS (LEVELS)
    ) u_pick_hot (
        .above (above_s),
        .sel   (hot_trip_select),
        .hit   (hot_hit)
    );

    // ------------------------------------------------------------------
    // Zone classification (never looks at the channel select)
    // ------------------------------------------------------------------
    reg [2:0] next_zone;

    always @* begin
        if (!temp_monitor_enable) begin
            next_zone = `BTZM_ZONE_OFF;
        end else if (cold_hit) begin
            next_zone = `BTZM_ZONE_COLD;
        end else if (!hot_hit) begin
            next_zone = `BTZM_ZONE_HOT;
        end else if (cool_hit) begin
            next_zone = `BTZM_ZONE_COOL;
        end else if (!warm_hit) begin
            next_zone = `BTZM_ZONE_WARM;
        end else begin
            next_zone = `BTZM_ZONE_NORMAL;
        end
    end

    wire zone_fault;
    wire zone_mod;

    assign zone_fault = (next_zone == `BTZM_ZONE_COLD) ||
                        (next_zone == `BTZM_ZONE_HOT);
    assign zone_mod   = (next_zone == `BTZM_ZONE_COOL) ||
                        (next_zone == `BTZM_ZONE_WARM);

    // ------------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------------
    function [31:0] reg_word;
        input [ADDR_W-1:0] addr;
        begin
            reg_word = 32'h0000_0000;
            if (addr == `BTZM_OFS_CFG_A) begin
                reg_word[7:0] = trip_cfg;
            end else if (addr == `BTZM_OFS_CFG_F) begin
                reg_word[`BTZM_EN_BIT] = temp_monitor_enable;
                reg_word[`BTZM_MOD_LSB+5:`BTZM_MOD_LSB] =
                    modified_charge_current;
            end else if (addr == `BTZM_OFS_CFG_H) begin
                reg_word[`BTZM_MOD_LSB+5:`BTZM_MOD_LSB] =
                    modified_charge_voltage;
            end else if (addr == `BTZM_OFS_NORMAL) begin
                reg_word[5:0] = normal_charge_voltage;
                reg_word[`BTZM_NCUR_LSB+5:`BTZM_NCUR_LSB] =
                    normal_charge_current;
            end else if (addr == `BTZM_OFS_CFG_I) begin
                reg_word[3:0] = monitor_channel_select;
            end else if (addr == `BTZM_OFS_STATUS_A) begin
                reg_word[2:0] = temp_zone_status;
                reg_word[`BTZM_ST_BIAS_BIT]  = thermistor_bias_pin;
                reg_word[`BTZM_ST_FAULT_BIT] = in_fault;
                reg_word[`BTZM_ST_MOD_BIT]   = modified_state;
            end else if (addr == `BTZM_OFS_INT_FLAGS) begin
                reg_word[0] = temp_zone_change_flag;
            end else if (addr == `BTZM_OFS_INT_MASK) begin
                reg_word[0] = temp_zone_change_mask;
            end
        end
    endfunction

    function mapped;
        input [ADDR_W-1:0] addr;
        begin
            mapped = (addr[1:0] == 2'h0) &&
                     (addr <= `BTZM_OFS_INT_MASK);
        end
    endfunction

    wire [31:0] lane_mask;
    wire [31:0] merged;
    wire        do_write;
    wire        wr_ok;

    assign lane_mask = {{8{w_strb[3]}}, {8{w_strb[2]}},
                        {8{w_strb[1]}}, {8{w_strb[0]}}};
    assign merged    = (reg_word(aw_addr) & ~lane_mask) |
                       (w_data & lane_mask);
    assign do_write  = aw_got && w_got && !s_axi_bvalid;
    assign wr_ok     = do_write && mapped(aw_addr);

    // ------------------------------------------------------------------
    // AXI4-Lite channels
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `BTZM_RESP_OKAY;
            aw_got        <= 1'b0;
            w_got         <= 1'b0;
            aw_addr       <= {ADDR_W{1'b0}};
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BTZM_RESP_OKAY;
        end else begin
            if (s_axi_awready && s_axi_awvalid) begin
                aw_got        <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wready && s_axi_wvalid) begin
                w_got        <= 1'b1;
                w_data       <= s_axi_wdata;
                w_strb       <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got       <= 1'b0;
                w_got        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= mapped(aw_addr) ? `BTZM_RESP_OKAY :
                                                  `BTZM_RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
            if (s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= reg_word(s_axi_araddr);
                s_axi_rresp   <= mapped(s_axi_araddr) ? `BTZM_RESP_OKAY :
                                                        `BTZM_RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            trip_cfg                <= `BTZM_RST_CFG_A;
            temp_monitor_enable     <= `BTZM_RST_EN;
            modified_charge_current <= `BTZM_RST_CODE6;
            modified_charge_voltage <= `BTZM_RST_CODE6;
            normal_charge_voltage   <= `BTZM_RST_CODE6;
            normal_charge_current   <= `BTZM_RST_CODE6;
            monitor_channel_select  <= `BTZM_RST_MUX;
            temp_zone_change_mask   <= `BTZM_RST_MASK;
        end else if (wr_ok) begin
            if (aw_addr == `BTZM_OFS_CFG_A) begin
                trip_cfg <= merged[7:0];
            end else if (aw_addr == `BTZM_OFS_CFG_F) begin
                temp_monitor_enable     <= merged[`BTZM_EN_BIT];
                modified_charge_current <=
                    merged[`BTZM_MOD_LSB+5:`BTZM_MOD_LSB];
            end else if (aw_addr == `BTZM_OFS_CFG_H) begin
                modified_charge_voltage <=
                    merged[`BTZM_MOD_LSB+5:`BTZM_MOD_LSB];
            end else if (aw_addr == `BTZM_OFS_NORMAL) begin
                normal_charge_voltage <= merged[5:0];
                normal_charge_current <=
                    merged[`BTZM_NCUR_LSB+5:`BTZM_NCUR_LSB];
            end else if (aw_addr == `BTZM_OFS_CFG_I) begin
                monitor_channel_select <= merged[3:0];
            end else if (aw_addr == `BTZM_OFS_INT_MASK) begin
                temp_zone_change_mask <= merged[0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Zone status, change flag and interrupt
    // ------------------------------------------------------------------
    wire zone_changed;
    wire flag_clear;

    assign zone_changed = (next_zone != temp_zone_status);
    assign flag_clear   = wr_ok && (aw_addr == `BTZM_OFS_INT_FLAGS) &&
                          w_strb[0] && w_data[0];

    always @(posedge clk) begin
        if (!rst_n) begin
            temp_zone_status      <= `BTZM_ZONE_OFF;
            temp_zone_change_flag <= 1'b0;
            irq                   <= 1'b0;
        end else begin
            temp_zone_status <= next_zone;
            // A change in the clearing cycle keeps the flag set
            if (zone_changed) begin
                temp_zone_change_flag <= 1'b1;
            end else if (flag_clear) begin
                temp_zone_change_flag <= 1'b0;
            end
            irq <= (temp_zone_change_flag || zone_changed) &&
                   !temp_zone_change_mask;
        end
    end

    // ------------------------------------------------------------------
    // Charge parameters and temperature fault handling
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            in_fault             <= 1'b0;
            saved_state          <= 4'h0;
            chg_state_out        <= 4'h0;
            charge_stop          <= 1'b0;
            modified_state       <= 1'b0;
            charge_voltage_sel   <= `BTZM_RST_CODE6;
            charge_current_sel   <= `BTZM_RST_CODE6;
            timer_pause          <= 1'b0;
            fast_timer_restart   <= 1'b0;
            topoff_timer_restart <= 1'b0;
        end else begin
            fast_timer_restart   <= 1'b0;
            topoff_timer_restart <= 1'b0;
            modified_state       <= zone_mod;
            if (zone_mod) begin
                charge_voltage_sel <= modified_charge_voltage;
                charge_current_sel <= modified_charge_current;
            end else begin
                charge_voltage_sel <= normal_charge_voltage;
                charge_current_sel <= normal_charge_current;
            end
            if (!in_fault && zone_fault) begin
                in_fault      <= 1'b1;
                saved_state   <= chg_state_in;
                chg_state_out <= `BTZM_CHG_TEMP_FAULT;
                charge_stop   <= 1'b1;
                timer_pause   <= 1'b1;
            end else if (in_fault && !zone_fault) begin
                in_fault             <= 1'b0;
                chg_state_out        <= saved_state;
                charge_stop          <= 1'b0;
                timer_pause          <= 1'b0;
                fast_timer_restart   <= 1'b1;
                topoff_timer_restart <= 1'b1;
            end else if (in_fault) begin
                chg_state_out <= `BTZM_CHG_TEMP_FAULT;
            end else begin
                chg_state_out <= chg_state_in;
            end
        end
    end

    // ------------------------------------------------------------------
    // Thermistor bias and analog monitor control
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            thermistor_bias_pin   <= 1'b0;
            analog_monitor_enable <= 1'b0;
        end else begin
            // Off unless one of the three conditions holds
            thermistor_bias_pin <=
                (supply_s && temp_monitor_enable) ||
                (monitor_channel_select == `BTZM_MUX_SENSE) ||
                (monitor_channel_select == `BTZM_MUX_BIAS);
            analog_monitor_enable <=
                (monitor_channel_select != `BTZM_MUX_OFF);
        end
    end

endmodule

`default_nettype wire

// File: tb/btzm_checker.sv
// Port-level properties of the zone monitor.
// Assumes it is bound to btzm_monitor; port names match its ports.
`timescale 1ns/10ps
`default_nettype none
`include "btzm_consts.vh"
module btzm_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic       charge_stop,
    input wire logic [3:0] chg_state_out,
    input wire logic       timer_pause,
    input wire logic       modified_state,
    input wire logic       fast_timer_restart,
    input wire logic       topoff_timer_restart,
    input wire logic [3:0] monitor_channel_select,
    input wire logic       thermistor_bias_pin,
    input wire logic       analog_monitor_enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence node_sel;
        (monitor_channel_select == `BTZM_MUX_SENSE ||
         monitor_channel_select == `BTZM_MUX_BIAS) [*2];
    endsequence
    wr_answer_a:
    assert property (wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write got no response");
    wr_busy_a:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read got no response");
    rd_busy_a:
    assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    fault_state_a:
    assert property (charge_stop |->
        chg_state_out == `BTZM_CHG_TEMP_FAULT && timer_pause)
        else $error("fault without fault state");
    zone_excl_a:
    assert property (!(modified_state && charge_stop))
        else $error("modified and fault together");
    fault_exit_a:
    assert property ($fell(charge_stop) |->
        ##[0:1] (fast_timer_restart && topoff_timer_restart))
        else $error("no timer restart at fault exit");
    node_bias_a:
    assert property (node_sel |-> thermistor_bias_pin)
        else $error("bias off while node selected");
    mon_enable_a:
    assert property ($stable(monitor_channel_select) |->
        analog_monitor_enable == (monitor_channel_select != `BTZM_MUX_OFF))
        else $error("monitor enable wrong");
endmodule
bind btzm_monitor btzm_checker chk (.*);
`default_nettype wire

// File: tb/btzm_ntc_model.sv
// Comparator bank facing the thermistor sense pin.
// Assumes the bench sets the sense voltage as a position among levels.
`timescale 1ns/10ps
`default_nettype none
module btzm_ntc_model (
    input  wire logic [3:0]  sense_pos,
    output var  logic [11:0] trip_above
);
    // Level voltage falls with index, so a colder cell trips more levels
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            trip_above[i] = (i >= sense_pos);
        end
    end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Bench: register access, zone sweep, interrupt and bias checks.
// Assumes the design top and the comparator model sit beside it.
`timescale 1ns/10ps
`default_nettype none
`include "btzm_consts.vh"
module tb;
    logic        clk = 0, rst_n = 0, f, m;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, chg_state_in = '0, chg_state_out;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, charge_input_supply = 1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, charge_stop, modified_state, timer_pause;
    logic        fast_timer_restart, topoff_timer_restart, irq;
    logic        thermistor_bias_pin, analog_monitor_enable;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [5:0]  charge_voltage_sel, charge_current_sel;
    logic [3:0]  monitor_channel_select, sense_pos = 4'h4;
    logic [11:0] trip_above;
    logic [3:0]  pos_t [8] = '{4'h0, 4'h1, 4'h4, 4'h7, 4'h9, 4'h4, 4'h2, 4'h9};
    logic [2:0]  zone_t [8] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h3, 3'h1, 3'h4};
    integer      n_errors = 0, checks = 0, k;
    btzm_monitor uut (.*);
    btzm_ntc_model ntc (.sense_pos(sense_pos), .trip_above(trip_above));
    initial begin
        forever #5 clk = ~clk;
    end
    task finish_test;
        $display("mismatches %0d of %0d checks", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task step(inout integer i);
        @(posedge clk);
        i++;
        if (i > 40) begin
            chk("handshake", 1, 0);
            finish_test;
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        integer i;
        i = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            step(i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk("bresp", r, s_axi_bresp);
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r,
            input string s);
        integer i;
        i = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            step(i);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s, e, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        rd(`BTZM_OFS_CFG_A, 0, 0, "cfg_a");
        rd(`BTZM_OFS_INT_MASK, 1, 0, "int_mask");
        rd(8'h20, 0, 2, "unmapped");
        chk("bias", 0, thermistor_bias_pin);
        wr(`BTZM_OFS_NORMAL, 32'h1522, 0);
        wr(`BTZM_OFS_CFG_H, 32'h28, 0);
        wr(`BTZM_OFS_CFG_F, 32'h31, 0);
        wr(8'h24, 32'h1, 2);
        repeat (4) @(posedge clk);
        chk("bias", 1, thermistor_bias_pin);
        wr(`BTZM_OFS_CFG_I, `BTZM_MUX_BIAS, 0);
        chg_state_in <= 4'h3;
        for (k = 0; k < 8; k++) begin
            if (k == 6) wr(`BTZM_OFS_CFG_A, 32'hc3, 0);
            sense_pos <= pos_t[k];
            repeat (4) @(posedge clk);
            f = zone_t[k] == 1 || zone_t[k] == 5;
            m = zone_t[k] == 2 || zone_t[k] == 4;
            rd(`BTZM_OFS_STATUS_A, {m, f, 1'b1, zone_t[k]}, 0,
               "status");
            chk("stop", f, charge_stop);
            chk("pause", f, timer_pause);
            chk("state", f ? 4'hf : 4'h3, chg_state_out);
            chk("volt", m ? 6'h0a : 6'h22, charge_voltage_sel);
            chk("curr", m ? 6'h0c : 6'h15, charge_current_sel);
        end
        chk("irq", 0, irq);
        wr(`BTZM_OFS_INT_MASK, 0, 0);
        repeat (2) @(posedge clk);
        chk("irq", 1, irq);
        wr(`BTZM_OFS_INT_FLAGS, 1, 0);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        sense_pos <= 4'h0;
        repeat (4) @(posedge clk);
        chk("stop", 1, charge_stop);
        wr(`BTZM_OFS_CFG_F, 32'h30, 0);
        wr(`BTZM_OFS_STATUS_A, 32'h3f, 0);
        repeat (4) @(posedge clk);
        rd(`BTZM_OFS_STATUS_A, 32'h08, 0, "status");
        chk("stop", 0, charge_stop);
        wr(`BTZM_OFS_CFG_I, `BTZM_MUX_OFF, 0);
        repeat (2) @(posedge clk);
        chk("bias", 0, thermistor_bias_pin);
        wr(`BTZM_OFS_CFG_I, `BTZM_MUX_SENSE, 0);
        repeat (2) @(posedge clk);
        chk("bias", 1, thermistor_bias_pin);
        finish_test;
    end
endmodule
`default_nettype wire
